// ===== rtl/pim_pkg.sv
package pim_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned DISAGREE_MS = 100;
  localparam int unsigned DISAGREE_CYCLES = (CLK_HZ / 1000) * DISAGREE_MS;

  // ----------------------------------------------------------------
  // Resolver angle
  // ----------------------------------------------------------------
  localparam int ANGLE_W = 9;
  localparam logic [ANGLE_W-1:0] ANGLE_FULL = 9'h168;
  localparam logic [ANGLE_W-1:0] ANGLE_RST = 9'h000;

  // ----------------------------------------------------------------
  // Synchronised pin positions
  // ----------------------------------------------------------------
  localparam int PIN_COUNT = 7;
  localparam int PIN_OVERRUN = 0;
  localparam int PIN_USER_ONE = 1;
  localparam int PIN_USER_TWO = 2;
  localparam int PIN_PAIR_FIRST = 3;
  localparam int PIN_PAIR_SECOND = 4;
  localparam int PIN_SEL_OFF = 5;
  localparam int PIN_SEL_JOG = 6;
  localparam logic [PIN_COUNT-1:0] PIN_RST = 7'h00;

  // ----------------------------------------------------------------
  // Display fault codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CODE_NONE = 8'h00;
  localparam logic [7:0] CODE_OVERRUN = 8'h01;
  localparam logic [7:0] CODE_USER_ONE = 8'h33;
  localparam logic [7:0] CODE_USER_TWO = 8'h34;
  localparam logic [7:0] CODE_PAIR_FIRST = 8'h35;
  localparam logic [7:0] CODE_PAIR_SECOND = 8'h21;
  localparam logic [7:0] CODE_LOCKOUT = 8'h11;

endpackage

// ===== rtl/pim_sync_if.sv
`timescale 1ns/1ns
interface pim_sync_if #(parameter int W = 7);
  logic [W-1:0] raw;
  logic [W-1:0] sync;
  modport sync_side (input raw, output sync);
  modport user_side (output raw, input sync);
endinterface

// ===== rtl/pim_sync.sv
`timescale 1ns/1ns
module pim_sync #(
  parameter int W = 7
) (
  input wire logic clk_sys,
  input wire logic rst,
  pim_sync_if.sync_side sy
);
  import pim_pkg::*;

  typedef struct packed {
    logic [W-1:0] first;
    logic [W-1:0] second;
  } pim_sync_t;

  pim_sync_t s_q;
  pim_sync_t s_d;

  // ----------------------------------------------------------------
  // Two-stage synchroniser
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d.first = sy.raw;
    s_d.second = s_q.first;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign sy.sync = s_q.second;

  sync_delay_a:
    assert property (@(posedge clk_sys) disable iff (rst)
      !rst |-> ##2 (sy.sync == $past(sy.raw, 2)))
    else $error("synchroniser output is not the input two cycles late");

endmodule // pim_sync

// ===== rtl/pim_monitor.sv
`timescale 1ns/1ns
module pim_monitor #(
  parameter int unsigned DISAGREE_CYC = pim_pkg::DISAGREE_CYCLES,
  parameter int TMR_W = 22
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic overrun_sense,
  input wire logic user_one_in,
  input wire logic user_two_in,
  input wire logic paired_input_first,
  input wire logic paired_input_second,
  input wire logic stroke_sel_off,
  input wire logic stroke_sel_jog,
  input wire logic [pim_pkg::ANGLE_W-1:0] angle_deg,
  input wire logic [pim_pkg::ANGLE_W-1:0] overrun_tol,
  output logic emergency_halt,
  output logic top_stop,
  output logic lockout_relay_closed,
  output logic lockout_msg,
  output logic overrun_fault,
  output logic [7:0] fault_code,
  output logic [7:0] fault_code_aux
);
  import pim_pkg::*;

  typedef struct packed {
    logic ovr_prev;
    logic ref_valid;
    logic [ANGLE_W-1:0] ref_angle;
    logic ovr_flt;
    logic pair_first_flt;
    logic pair_second_flt;
    logic [TMR_W-1:0] dis_tmr;
    logic off_seen;
    logic lockout;
    logic relay_closed;
    logic halt;
    logic tstop;
    logic [7:0] code;
    logic [7:0] aux;
  } pim_state_t;

  localparam logic [TMR_W-1:0] DIS_LIMIT = TMR_W'(DISAGREE_CYC);

  pim_state_t s_q;
  pim_state_t s_d;
  logic [PIN_COUNT-1:0] pin_s;
  logic ovr_rise;
  logic [ANGLE_W-1:0] ang_diff;
  logic [ANGLE_W-1:0] ang_dist;
  logic ovr_bad;
  logic pair_dis;
  logic first_open;
  logic second_open;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  pim_sync_if #(.W(PIN_COUNT)) sy ();

  // two-stage sync of every field input
  assign sy.raw = {stroke_sel_jog, stroke_sel_off, paired_input_second, paired_input_first,
                   user_two_in, user_one_in, overrun_sense};

  pim_sync #(.W(PIN_COUNT)) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .sy(sy)
  );

  assign pin_s = sy.sync;

  // ----------------------------------------------------------------
  // Overrun angle check
  // ----------------------------------------------------------------
  assign ovr_rise = pin_s[PIN_OVERRUN] && !s_q.ovr_prev;
  assign ang_diff = (angle_deg >= s_q.ref_angle) ? angle_deg - s_q.ref_angle
                                                 : s_q.ref_angle - angle_deg;
  assign ang_dist = (ang_diff > (ANGLE_FULL >> 1)) ? ANGLE_FULL - ang_diff : ang_diff;
  // tolerance in whole degrees, wrap at 360
  assign ovr_bad = ang_dist > overrun_tol;

  // ----------------------------------------------------------------
  // Pair levels, open contact reads high
  // ----------------------------------------------------------------
  // paired inputs are healthy when grounded
  assign first_open = pin_s[PIN_PAIR_FIRST];
  assign second_open = pin_s[PIN_PAIR_SECOND];
  assign pair_dis = first_open ^ second_open;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.ovr_prev = pin_s[PIN_OVERRUN];
    // off then jog clears the latched faults
    if (pin_s[PIN_SEL_OFF])
    begin
      s_d.off_seen = 1'b1;
    end
    else if (s_q.off_seen && pin_s[PIN_SEL_JOG])
    begin
      s_d.off_seen = 1'b0;
      s_d.lockout = 1'b0;
      s_d.ovr_flt = 1'b0;
      s_d.pair_first_flt = 1'b0;
      s_d.pair_second_flt = 1'b0;
      s_d.ref_valid = 1'b0;
    end
    if (!pair_dis)
    begin
      s_d.dis_tmr = '0;
    end
    else if (s_q.dis_tmr != DIS_LIMIT)
    begin
      s_d.dis_tmr = s_q.dis_tmr + TMR_W'(1);
    end
    // open input or long disagreement sets the fault
    if (first_open || (pair_dis && first_open && s_q.dis_tmr == DIS_LIMIT))
    begin
      s_d.pair_first_flt = 1'b1;
    end
    if (second_open || (pair_dis && second_open && s_q.dis_tmr == DIS_LIMIT))
    begin
      s_d.pair_second_flt = 1'b1;
    end
    // learn the stroke angle on the first overrun edge
    if (ovr_rise && !s_q.ref_valid)
    begin
      s_d.ref_valid = 1'b1;
      s_d.ref_angle = angle_deg;
    end
    // angle drift latches the overrun fault
    else if (ovr_rise && ovr_bad)
    begin
      s_d.ovr_flt = 1'b1;
    end
    if (s_d.ovr_flt || s_d.pair_first_flt || s_d.pair_second_flt)
    begin
      s_d.lockout = 1'b1;
    end
    s_d.relay_closed = !s_d.lockout;
    // user one open halts at once
    s_d.halt = !pin_s[PIN_USER_ONE] || s_d.ovr_flt || s_d.pair_first_flt || s_d.pair_second_flt;
    // user two open stops at top
    s_d.tstop = !pin_s[PIN_USER_TWO];
    // code priority, pair then overrun then users
    s_d.aux = s_d.lockout ? CODE_LOCKOUT : CODE_NONE;
    if (s_d.pair_first_flt)
    begin
      s_d.code = CODE_PAIR_FIRST;
    end
    else if (s_d.pair_second_flt)
    begin
      s_d.code = CODE_PAIR_SECOND;
    end
    else if (s_d.ovr_flt)
    begin
      s_d.code = CODE_OVERRUN;
    end
    // open interlock shows its own code
    else if (!pin_s[PIN_USER_ONE])
    begin
      s_d.code = CODE_USER_ONE;
    end
    else if (!pin_s[PIN_USER_TWO])
    begin
      s_d.code = CODE_USER_TWO;
    end
    else
    begin
      s_d.code = CODE_NONE;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      s_q <= '0;
      s_q.relay_closed <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // relay opens with lockout
  assign emergency_halt = s_q.halt;
  assign top_stop = s_q.tstop;
  assign lockout_relay_closed = s_q.relay_closed;
  assign lockout_msg = s_q.lockout;
  assign overrun_fault = s_q.ovr_flt;
  assign fault_code = s_q.code;
  assign fault_code_aux = s_q.aux;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  ref_capture_a:
    assert property (@(posedge clk_sys) disable iff (rst)
      (ovr_rise && !s_q.ref_valid) |=> (s_q.ref_valid && s_q.ref_angle == $past(angle_deg)))
    else $error("overrun angle not learned");

  overrun_halt_a:
    assert property (@(posedge clk_sys) disable iff (rst)
      (ovr_rise && s_q.ref_valid && ovr_bad) |=> (overrun_fault && emergency_halt && lockout_msg))
    else $error("overrun drift did not halt");

  user_one_a:
    assert property (@(posedge clk_sys) disable iff (rst)
      (!rst && !pin_s[PIN_USER_ONE] && !s_d.lockout)
        |=> (emergency_halt && fault_code == CODE_USER_ONE))
    else $error("user one open not reported");

  user_two_a:
    assert property (@(posedge clk_sys) disable iff (rst)
      (!pin_s[PIN_USER_TWO] && pin_s[PIN_USER_ONE] && !s_d.lockout)
        |=> (top_stop && !emergency_halt && fault_code == CODE_USER_TWO))
    else $error("user two open not reported");

  pair_first_a:
    assert property (@(posedge clk_sys) disable iff (rst)
      first_open |=> (fault_code == CODE_PAIR_FIRST && fault_code_aux == CODE_LOCKOUT))
    else $error("pair first fault codes wrong");

  pair_lock_a:
    assert property (@(posedge clk_sys) disable iff (rst)
      second_open |=> (emergency_halt && !lockout_relay_closed && lockout_msg))
    else $error("pair fault did not lock out");

  dis_timer_a:
    assert property (@(posedge clk_sys) disable iff (rst)
      (pair_dis && s_q.dis_tmr != DIS_LIMIT) |=> (s_q.dis_tmr == $past(s_q.dis_tmr) + TMR_W'(1)))
    else $error("disagreement timer stalled");

  dis_saturate_a:
    assert property (@(posedge clk_sys) disable iff (rst)
      (pair_dis && s_q.dis_tmr == DIS_LIMIT) |=> (s_q.dis_tmr == DIS_LIMIT))
    else $error("disagreement timer left its limit");

  lock_hold_a:
    assert property (@(posedge clk_sys) disable iff (rst)
      (lockout_msg && !s_q.off_seen) |=> lockout_msg)
    else $error("lockout cleared without off selection");

  lock_clear_a:
    assert property (@(posedge clk_sys) disable iff (rst)
      (lockout_msg && s_q.off_seen && !pin_s[PIN_SEL_OFF] && pin_s[PIN_SEL_JOG]
        && !first_open && !second_open && !ovr_rise) |=> !lockout_msg)
    else $error("lockout did not clear on jog");

endmodule // pim_monitor

// ===== dv/pim_field_model.sv
`timescale 1ns/1ns
module pim_field_model #(
  parameter int DWELL = 20
) (
  input wire logic [pim_pkg::ANGLE_W-1:0] angle_deg,
  input wire logic [pim_pkg::ANGLE_W-1:0] magnet_deg,
  input wire logic [3:0] open_req,
  output logic overrun_sense,
  output logic user_one_in,
  output logic user_two_in,
  output logic paired_input_first,
  output logic paired_input_second
);
  import pim_pkg::*;
  int diff;
  always_comb
  begin
    diff = (int'(angle_deg) + int'(ANGLE_FULL) - int'(magnet_deg)) % int'(ANGLE_FULL);
    overrun_sense = diff < DWELL;
  end
  assign user_one_in = !open_req[0];
  assign user_two_in = !open_req[1];
  assign paired_input_first = open_req[2];
  assign paired_input_second = open_req[3];
endmodule // pim_field_model

// ===== dv/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import pim_pkg::*;
  logic clk_sys, rst, sel_off, sel_jog, ovs, u1, u2, pf, ps;
  logic [ANGLE_W-1:0] angle, mag;
  logic [3:0] open_req;
  logic halt, tstop, relay, msg, ovf;
  logic [7:0] code, aux;
  int errors, samples_checked;
  localparam logic [20:0] IDLE = {5'b00100, CODE_NONE, CODE_NONE};
  localparam logic [20:0] PF = {5'b10010, CODE_PAIR_FIRST, CODE_LOCKOUT};

  pim_field_model fm (.angle_deg(angle), .magnet_deg(mag), .open_req(open_req),
    .overrun_sense(ovs), .user_one_in(u1), .user_two_in(u2),
    .paired_input_first(pf), .paired_input_second(ps));
  pim_monitor #(.DISAGREE_CYC(20), .TMR_W(22)) uut (.clk_sys(clk_sys), .rst(rst),
    .overrun_sense(ovs), .user_one_in(u1), .user_two_in(u2),
    .paired_input_first(pf), .paired_input_second(ps), .stroke_sel_off(sel_off),
    .stroke_sel_jog(sel_jog), .angle_deg(angle), .overrun_tol(9'h005),
    .emergency_halt(halt), .top_stop(tstop), .lockout_relay_closed(relay),
    .lockout_msg(msg), .overrun_fault(ovf), .fault_code(code), .fault_code_aux(aux));

  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // Crank turns one degree per cycle
  always @(posedge clk_sys) angle <= (angle == 9'h167) ? 9'h000 : angle + 9'h001;

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task end_of_test;
    if (errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task chk(input string nm, input logic [20:0] e);
    samples_checked++;
    if ({halt, tstop, relay, msg, ovf, code, aux} !== e)
    begin
      errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, {halt, tstop, relay, msg, ovf, code, aux});
    end
  endtask

  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task drive(input logic [3:0] o);
    @(posedge clk_sys);
    open_req <= o;
    cyc(4);
  endtask

  task sel(input logic off, input logic jog);
    @(posedge clk_sys);
    sel_off <= off;
    sel_jog <= jog;
    cyc(4);
  endtask

  task clr;
    sel(1'b1, 1'b0);
    sel(1'b0, 1'b1);
    sel(1'b0, 1'b0);
  endtask

  // Wait for the crank to reach angle 0x12C, clear of the sensing window, move the magnet to m, then run n strokes
  task stroke(input logic [8:0] m, input int n);
    int k;
    k = 0;
    while (angle !== 9'h12C && k < 400)
    begin
      @(posedge clk_sys);
      k++;
    end
    if (k == 400)
    begin
      errors++;
      $display("MISMATCH angle_wait exp %h got %h", 9'h12C, angle);
      end_of_test();
    end
    mag <= m;
    cyc(360 * n);
  endtask

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    sel_off = 1'b0;
    sel_jog = 1'b0;
    open_req = 4'h0;
    mag = 9'h064;
    angle = 9'h000;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    cyc(6);
    chk("idle", IDLE);
    @(posedge clk_sys);
    open_req <= 4'h1;
    cyc(2);
    chk("sync_latency", IDLE);
    cyc(1);
    chk("user_one", {5'b10100, CODE_USER_ONE, CODE_NONE});
    drive(4'h3);
    chk("both_users", {5'b11100, CODE_USER_ONE, CODE_NONE});
    drive(4'h2);
    chk("user_two", {5'b01100, CODE_USER_TWO, CODE_NONE});
    drive(4'h0);
    chk("users_closed", IDLE);
    drive(4'h4);
    chk("pair_first", PF);
    cyc(24);
    chk("pair_disagree", PF);
    drive(4'h0);
    chk("pair_latched", PF);
    sel(1'b0, 1'b1);
    sel(1'b0, 1'b0);
    chk("jog_alone", PF);
    clr();
    chk("cleared", IDLE);
    drive(4'h8);
    chk("pair_second", {5'b10010, CODE_PAIR_SECOND, CODE_LOCKOUT});
    clr();
    chk("clear_refused", {5'b10010, CODE_PAIR_SECOND, CODE_LOCKOUT});
    drive(4'h0);
    clr();
    chk("cleared_two", IDLE);
    stroke(9'h064, 2);
    chk("same_angle", IDLE);
    stroke(9'h069, 1);
    chk("drift_at_tol", IDLE);
    stroke(9'h06A, 1);
    chk("overrun", {5'b10011, CODE_OVERRUN, CODE_LOCKOUT});
    end_of_test();
  end
endmodule // tb_top
